// File: common/erc_defs.vh
`ifndef ERC_DEFS_VH
`define ERC_DEFS_VH

// Oscillator clocks per instruction cycle and the phase numbers inside one
`define ERC_OSC_PER_INSTR   4
`define ERC_PH_READ         2'h0
`define ERC_PH_CAPTURE      2'h2
`define ERC_PH_COMMIT       2'h3
`define ERC_RATE_HIGH_FROM  2'h2

// Program memory sizes per variant (address bits)
`define ERC_PC_W_512        9
`define ERC_PC_W_1K         10
`define ERC_PC_W_2K         11
`define ERC_INSTR_W         12
`define ERC_DATA_W          8
`define ERC_DADDR_W         5

// Reset values
`define ERC_RESET_VECTOR    11'h000
`define ERC_NOP_WORD        12'h000
`define ERC_W_RESET         8'h00
`define ERC_FSR_RESET       8'h00
`define ERC_STATUS_RESET    3'h0

// Special register addresses in data memory
`define ERC_ADDR_INDIRECT   5'h00
`define ERC_ADDR_PCL        5'h02
`define ERC_ADDR_STATUS     5'h03
`define ERC_ADDR_FSR        5'h04

// Status bit positions
`define ERC_ST_C            0
`define ERC_ST_NIB          1
`define ERC_ST_Z            2

// File operation codes (instruction bits 9:6)
`define ERC_FOP_NOP         4'h0
`define ERC_FOP_MOVWF       4'h1
`define ERC_FOP_CLR         4'h2
`define ERC_FOP_SUBWF       4'h3
`define ERC_FOP_DECF        4'h4
`define ERC_FOP_IORWF       4'h5
`define ERC_FOP_ANDWF       4'h6
`define ERC_FOP_XORWF       4'h7
`define ERC_FOP_ADDWF       4'h8
`define ERC_FOP_MOVF        4'h9
`define ERC_FOP_COMF        4'ha
`define ERC_FOP_INCF        4'hb
`define ERC_FOP_RRF         4'hc
`define ERC_FOP_RLF         4'hd
`define ERC_FOP_SWAPF       4'he

// Literal operation codes (instruction bits 9:8)
`define ERC_LOP_MOVLW       2'h0
`define ERC_LOP_ADDLW       2'h1
`define ERC_LOP_ANDLW       2'h2
`define ERC_LOP_XORLW       2'h3

// ALU operation codes
`define ERC_ALU_PASSB       4'h0
`define ERC_ALU_PASSA       4'h1
`define ERC_ALU_ADD         4'h2
`define ERC_ALU_SUB         4'h3
`define ERC_ALU_AND         4'h4
`define ERC_ALU_OR          4'h5
`define ERC_ALU_XOR         4'h6
`define ERC_ALU_INC         4'h7
`define ERC_ALU_DEC         4'h8
`define ERC_ALU_COM         4'h9
`define ERC_ALU_RRC         4'ha
`define ERC_ALU_RLC         4'hb
`define ERC_ALU_SWAP        4'hc
`define ERC_ALU_CLR         4'hd

`endif

// File: testbench/erc_core_checker.sv
`timescale 1ns/1ps
`include "erc_defs.vh"

module erc_core_checker #(
    parameter PC_W = `ERC_PC_W_2K
) (
    // Clock, resets, mode
    input wire                    sys_clk_i,
    input wire                    rst_i,
    input wire                    master_reset_pin_n_i,
    input wire                    rc_mode_i,
    input wire                    instruction_rate_output_o,
    // Program bus
    input wire [PC_W-1:0]         prog_addr_o,
    input wire [`ERC_INSTR_W-1:0] prog_data_i,
    // Data bus
    input wire [`ERC_DADDR_W-1:0] data_addr_o,
    input wire [`ERC_DATA_W-1:0]  data_wdata_o,
    input wire                    data_we_o,
    input wire                    data_re_o,
    input wire [`ERC_DATA_W-1:0]  data_rdata_i,
    // Core state
    input wire [`ERC_DATA_W-1:0]  acc_o,
    input wire [2:0]              status_o
);
    wire rate = instruction_rate_output_o;

    default clocking cb @(posedge sys_clk_i); endclocking
    // The pin reset lags the pin, so both resets silence the timing checks
    default disable iff (rst_i || !master_reset_pin_n_i);

    AST_STROBES_EXCL: assert property (!(data_we_o && data_re_o))
        else $error("read and write strobes high together");
    AST_READ_PULSE: assert property (data_re_o |=> !data_re_o)
        else $error("read strobe longer than one clock");
    AST_ONE_WRITE: assert property (data_we_o |=> !data_we_o [*3])
        else $error("two writes within one instruction cycle");
    AST_READ_ADDR: assert property (data_re_o |=> $stable(data_addr_o))
        else $error("address moved while read data due");
    AST_NO_SPECIAL: assert property ((data_we_o || data_re_o) |-> !(data_addr_o inside
        {`ERC_ADDR_INDIRECT, `ERC_ADDR_PCL, `ERC_ADDR_STATUS, `ERC_ADDR_FSR}))
        else $error("special register address on data bus");
    AST_PC_STANDS: assert property ($changed(prog_addr_o) |=> $stable(prog_addr_o) [*3])
        else $error("fetch address held less than four clocks");
    AST_RATE_OFF: assert property (!rc_mode_i ##1 !rc_mode_i |-> !rate)
        else $error("rate output active outside RC mode");
    AST_RATE_SHAPE: assert property ($rose(rate) && rc_mode_i |->
        rate ##1 rate ##1 !rate ##1 !rate ##1 rate)
        else $error("rate output not a quarter of the clock");
    AST_PIN_RESET: assert property (disable iff (rst_i)
        !master_reset_pin_n_i [*6] |-> acc_o == 8'h00 && status_o == 3'h0
        && prog_addr_o == {PC_W{1'b0}} && !data_we_o && !data_re_o)
        else $error("core not held in reset by low pin");

    COV_WALK: cover property (data_re_o ##3 data_we_o);
    COV_RATE: cover property ($rose(rate));
    COV_FETCH: cover property ($changed(prog_addr_o));
endmodule

bind erc_core erc_core_checker #(.PC_W(PC_W)) i_erc_core_checker (
    .sys_clk_i, .rst_i, .master_reset_pin_n_i, .rc_mode_i, .instruction_rate_output_o,
    .prog_addr_o, .prog_data_i, .data_addr_o, .data_wdata_o, .data_we_o, .data_re_o,
    .data_rdata_i, .acc_o, .status_o
);

// File: testbench/erc_core_tb.sv
`timescale 1ns/1ps
`include "erc_defs.vh"

module erc_core_tb;
    localparam int PC_W = 11;

    // Core pins
    logic                    sys_clk_i;
    logic                    rst_i;
    logic                    master_reset_pin_n_i;
    logic                    rc_mode_i;
    logic                    instruction_rate_output_o;
    logic [PC_W-1:0]         prog_addr_o;
    logic [`ERC_INSTR_W-1:0] prog_data_i;
    logic [`ERC_DADDR_W-1:0] data_addr_o;
    logic [`ERC_DATA_W-1:0]  data_wdata_o;
    logic                    data_we_o;
    logic                    data_re_o;
    logic [`ERC_DATA_W-1:0]  data_rdata_i;
    logic [`ERC_DATA_W-1:0]  acc_o;
    logic [2:0]              status_o;
    int                      mismatches = 0;
    int                      checks_done = 0;

    erc_core #(.PC_W(PC_W)) i_erc_core (
        .sys_clk_i, .rst_i, .master_reset_pin_n_i, .rc_mode_i, .instruction_rate_output_o,
        .prog_addr_o, .prog_data_i, .data_addr_o, .data_wdata_o, .data_we_o, .data_re_o,
        .data_rdata_i, .acc_o, .status_o);

    erc_mem_model #(.PC_W(PC_W)) i_erc_mem_model (
        .sys_clk_i, .prog_addr_i(prog_addr_o), .prog_data_o(prog_data_i),
        .data_addr_i(data_addr_o), .data_wdata_i(data_wdata_o), .data_we_i(data_we_o),
        .data_re_i(data_re_o), .data_rdata_o(data_rdata_i));

    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic pm(input int a, input logic [11:0] w);
        i_erc_mem_model.prog_mem[a] = w;
    endtask

    // Core sits in reset while a new program is written
    task automatic hold();
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        for (int i = 0; i < 16; i++) pm(i, 12'h000);
    endtask

    // Programs end in a jump to themselves; wait for it, then let the tail retire
    task automatic park(input logic [11:0] last);
        int n;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            n++;
        end while (prog_addr_o !== last[PC_W-1:0] && n < 400);
        chk("parked pc", last, {1'b0, prog_addr_o});
        repeat (16) @(posedge sys_clk_i);
    endtask

    task automatic run(input logic [11:0] last);
        rst_i <= 1'b0;
        park(last);
    endtask

    task automatic t_add();
        hold();
        pm(0, 12'h40f);
        pm(1, 12'h501);
        pm(2, 12'h802);
        run(12'h002);
        chk("acc", 12'h010, {4'h0, acc_o});
        chk("status", 12'h002, {9'h0, status_o});
        $display("test add done");
    endtask

    // Word after the jump must be dropped; result wraps to zero
    task automatic t_wrap();
        hold();
        pm(0, 12'h802);
        pm(1, 12'h455);
        pm(2, 12'h4ff);
        pm(3, 12'h501);
        pm(4, 12'h804);
        run(12'h004);
        chk("acc", 12'h000, {4'h0, acc_o});
        chk("status", 12'h007, {9'h0, status_o});
        $display("test wrap done");
    endtask

    task automatic t_sub();
        hold();
        pm(0, 12'h410);
        pm(1, 12'h068);
        pm(2, 12'h401);
        pm(3, 12'h0e8);
        pm(4, 12'h804);
        run(12'h004);
        chk("file", 12'h00f, {4'h0, i_erc_mem_model.data_mem[8]});
        chk("status", 12'h001, {9'h0, status_o});
        $display("test sub done");
    endtask

    task automatic t_rot();
        hold();
        pm(0, 12'h481);
        pm(1, 12'h069);
        pm(2, 12'h349);
        pm(3, 12'h803);
        run(12'h003);
        chk("acc", 12'h002, {4'h0, acc_o});
        chk("status", 12'h001, {9'h0, status_o});
        chk("file", 12'h081, {4'h0, i_erc_mem_model.data_mem[9]});
        $display("test rotate done");
    endtask

    task automatic t_pin();
        @(posedge sys_clk_i);
        master_reset_pin_n_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        chk("acc in reset", 12'h000, {4'h0, acc_o});
        chk("pc in reset", 12'h000, {1'b0, prog_addr_o});
        chk("status in reset", 12'h000, {9'h0, status_o});
        @(posedge sys_clk_i);
        master_reset_pin_n_i <= 1'b1;
        park(12'h003);
        chk("acc rerun", 12'h002, {4'h0, acc_o});
        $display("test pin reset done");
    endtask

    // Pointer write, indirect store, then a jump by writing the program counter
    task automatic t_ind();
        hold();
        pm(0, 12'h40a);
        pm(1, 12'h064);
        pm(2, 12'h45a);
        pm(3, 12'h060);
        pm(4, 12'h407);
        pm(5, 12'h062);
        pm(6, 12'h4ee);
        pm(7, 12'h433);
        pm(8, 12'h808);
        run(12'h008);
        chk("file", 12'h05a, {4'h0, i_erc_mem_model.data_mem[10]});
        chk("acc", 12'h033, {4'h0, acc_o});
        $display("test indirect done");
    endtask

    task automatic t_logic();
        hold();
        pm(0, 12'h43c);
        pm(1, 12'h068);
        pm(2, 12'h40f);
        pm(3, 12'h148);
        pm(4, 12'h6f0);
        pm(5, 12'h730);
        pm(6, 12'h806);
        run(12'h006);
        chk("acc", 12'h000, {4'h0, acc_o});
        chk("status", 12'h004, {9'h0, status_o});
        $display("test logic done");
    endtask

    task automatic t_rate();
        int n;
        logic [7:0] seen;
        seen = 8'h00;
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk_i);
            seen = {seen[6:0], instruction_rate_output_o};
        end
        chk("rate off", 12'h000, {4'h0, seen});
        @(posedge sys_clk_i);
        rc_mode_i <= 1'b1;
        n = 0;
        do begin
            @(negedge sys_clk_i);
            seen = {seen[6:0], instruction_rate_output_o};
            n++;
        end while (seen[1:0] !== 2'b01 && n < 40);
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk_i);
            seen = {seen[6:0], instruction_rate_output_o};
        end
        chk("rate pattern", 12'h099, {4'h0, seen});
        $display("test rate done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        rst_i = 1'b1;
        master_reset_pin_n_i = 1'b1;
        rc_mode_i = 1'b0;
        repeat (20) @(posedge sys_clk_i);
        t_add();
        t_wrap();
        t_sub();
        t_rot();
        t_pin();
        t_ind();
        t_logic();
        t_rate();
        close_out();
    end

    // Whole run is a few hundred clocks; this allows ample margin
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
endmodule

// File: testbench/erc_mem_model.sv
`timescale 1ns/1ps
`include "erc_defs.vh"

module erc_mem_model #(
    parameter PC_W = `ERC_PC_W_2K
) (
    // Clock
    input  wire                    sys_clk_i,
    // Program bus
    input  wire [PC_W-1:0]         prog_addr_i,
    output wire [`ERC_INSTR_W-1:0] prog_data_o,
    // Data bus
    input  wire [`ERC_DADDR_W-1:0] data_addr_i,
    input  wire [`ERC_DATA_W-1:0]  data_wdata_i,
    input  wire                    data_we_i,
    input  wire                    data_re_i,
    output reg  [`ERC_DATA_W-1:0]  data_rdata_o
);
    logic [`ERC_INSTR_W-1:0] prog_mem [0:15];
    logic [`ERC_DATA_W-1:0]  data_mem [0:31];

    initial begin
        data_rdata_o = 8'h00;
        for (int i = 0; i < 32; i++) data_mem[i] = 8'h00;
        for (int i = 0; i < 16; i++) prog_mem[i] = 12'h000;
    end

    // Whole word with no wait state; beyond the small table it reads as a no-op
    assign prog_data_o = (prog_addr_i < 16) ? prog_mem[prog_addr_i[3:0]] : 12'h000;

    // Read data is good only in the cycle after the strobe, so it toggles otherwise
    always @(posedge sys_clk_i) begin
        if (data_we_i) begin
            data_mem[data_addr_i] <= data_wdata_i;
        end
        if (data_re_i) begin
            data_rdata_o <= data_mem[data_addr_i];
        end else begin
            data_rdata_o <= ~data_rdata_o;
        end
    end
endmodule

// File: verilog/erc_alu.v
`timescale 1ns/1ps
`include "erc_defs.vh"

module erc_alu (
    // Operation select and operands
    input  wire [3:0] op_i,
    input  wire [7:0] acc_i,
    input  wire [7:0] opnd_i,
    input  wire       carry_i,
    // Result and flags
    output reg  [7:0] result_o,
    output reg        carry_o,
    output reg        nibble_o,
    output wire       zero_o
);

    reg [8:0] sum9;
    reg [4:0] sum5;

    always @* begin
        sum9     = 9'h000;
        sum5     = 5'h00;
        result_o = 8'h00;
        carry_o  = carry_i;
        nibble_o = 1'b0;
        case (op_i)
            `ERC_ALU_PASSB: result_o = opnd_i;
            `ERC_ALU_PASSA: result_o = acc_i;
            `ERC_ALU_ADD: begin
                sum9     = {1'b0, opnd_i} + {1'b0, acc_i};
                sum5     = {1'b0, opnd_i[3:0]} + {1'b0, acc_i[3:0]};
                result_o = sum9[7:0];
                carry_o  = sum9[8];
                nibble_o = sum5[4];
            end
            // Operand minus accumulator in two's complement; carry out high means no borrow
            `ERC_ALU_SUB: begin
                sum9     = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
                sum5     = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
                result_o = sum9[7:0];
                carry_o  = sum9[8];
                nibble_o = sum5[4];
            end
            `ERC_ALU_AND:  result_o = acc_i & opnd_i;
            `ERC_ALU_OR:   result_o = acc_i | opnd_i;
            `ERC_ALU_XOR:  result_o = acc_i ^ opnd_i;
            `ERC_ALU_INC:  result_o = opnd_i + 8'h01;
            `ERC_ALU_DEC:  result_o = opnd_i - 8'h01;
            `ERC_ALU_COM:  result_o = ~opnd_i;
            `ERC_ALU_RRC: begin
                result_o = {carry_i, opnd_i[7:1]};
                carry_o  = opnd_i[0];
            end
            `ERC_ALU_RLC: begin
                result_o = {opnd_i[6:0], carry_i};
                carry_o  = opnd_i[7];
            end
            `ERC_ALU_SWAP: result_o = {opnd_i[3:0], opnd_i[7:4]};
            `ERC_ALU_CLR:  result_o = 8'h00;
            default:       result_o = 8'h00;
        endcase
    end

    assign zero_o = (result_o == 8'h00);

endmodule

// File: verilog/erc_core.v
// Notes on behaviour
// RULE1: A whole 12-bit instruction word is taken from program memory in one cycle on its own bus.
// RULE2: The next instruction is fetched while the current one executes.
// RULE3: Every instruction takes one instruction cycle; a branch takes one more as the fetch is dropped.
// RULE4: The program counter spans 512, 1K or 2K words by a width parameter; memory is internal. Here program memory sits outside the core on the program bus.
// RULE5: Program counter, status and pointer sit in data space, reached directly or via the pointer.
// RULE6: The ALU works on bytes and adds, subtracts, shifts and does logic.
// RULE7: Arithmetic is two's complement.
// RULE8: Two-operand instructions take the accumulator and a file register or a literal.
// RULE9: Single-operand instructions take a file register and send the result to it or the accumulator.
// RULE10: The accumulator is an 8-bit register with no data address.
// RULE11: Instructions update carry, nibble carry and zero as their class says.
// RULE12: In subtraction carry and nibble carry give the byte and low-nibble borrow (high = none).
// RULE13: In RC mode the rate output runs at a quarter of the oscillator, one period per instruction.
// RULE14: The master reset pin is active low and holds the core in reset while low.
// RULE15: Zero is set when the result of a zero-affecting instruction is zero, else cleared.
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "erc_defs.vh"

module erc_core #(
    parameter PC_W = `ERC_PC_W_2K
) (
    // Oscillator input and resets
    input  wire                    sys_clk_i,
    input  wire                    rst_i,
    input  wire                    master_reset_pin_n_i,
    // Oscillator mode select
    input  wire                    rc_mode_i,
    output wire                    instruction_rate_output_o,
    // Program memory bus
    output wire [PC_W-1:0]         prog_addr_o,
    input  wire [`ERC_INSTR_W-1:0] prog_data_i,
    // Data memory bus
    output wire [`ERC_DADDR_W-1:0] data_addr_o,
    output wire [`ERC_DATA_W-1:0]  data_wdata_o,
    output wire                    data_we_o,
    output wire                    data_re_o,
    input  wire [`ERC_DATA_W-1:0]  data_rdata_i,
    // Observation of core state
    output wire [`ERC_DATA_W-1:0]  acc_o,
    output wire [2:0]              status_o
);

    // Pin synchroniser and reset hold
    reg        mr_s1_reg;
    reg        mr_s2_reg;
    reg        mr_s3_reg;
    reg        mr_hold_reg;
    wire       core_rst;

    // Phase counter and rate output
    reg  [1:0] phase_reg;
    reg  [1:0] phase_next;
    reg        rate_reg;
    wire       commit_en;

    // Architectural state
    reg  [PC_W-1:0]         pc_reg;
    reg  [`ERC_INSTR_W-1:0] instr_reg;
    reg  [7:0]              acc_reg;
    reg  [7:0]              fsr_reg;
    reg  [2:0]              status_reg;
    reg  [7:0]              opnd_reg;

    // Data bus outputs
    reg  [`ERC_DADDR_W-1:0] daddr_reg;
    reg  [7:0]              dwdata_reg;
    reg                     dwe_reg;
    reg                     dre_reg;

    // Decode
    wire                    is_goto;
    wire                    is_lit;
    wire                    is_file;
    wire [3:0]              fop;
    wire [1:0]              lop;
    wire                    dest_f;
    wire [`ERC_DADDR_W-1:0] faddr;
    wire [`ERC_DADDR_W-1:0] eaddr;
    wire [3:0]              alu_op;
    wire [2:0]              flag_mask;
    wire                    wr_acc;
    wire                    wr_file;
    wire                    needs_read;
    wire [7:0]              alu_b;
    wire [7:0]              alu_y;
    wire                    alu_c;
    wire                    alu_nib;
    wire                    alu_z;
    wire                    status_written;
    localparam [10:0]       RESET_PC = `ERC_RESET_VECTOR;

    // File operation to ALU operation
    function [3:0] fop_to_alu;
        input [3:0] op;
        begin
            case (op)
                `ERC_FOP_MOVWF: fop_to_alu = `ERC_ALU_PASSA;
                `ERC_FOP_CLR:   fop_to_alu = `ERC_ALU_CLR;
                `ERC_FOP_SUBWF: fop_to_alu = `ERC_ALU_SUB;
                `ERC_FOP_DECF:  fop_to_alu = `ERC_ALU_DEC;
                `ERC_FOP_IORWF: fop_to_alu = `ERC_ALU_OR;
                `ERC_FOP_ANDWF: fop_to_alu = `ERC_ALU_AND;
                `ERC_FOP_XORWF: fop_to_alu = `ERC_ALU_XOR;
                `ERC_FOP_ADDWF: fop_to_alu = `ERC_ALU_ADD;
                `ERC_FOP_MOVF:  fop_to_alu = `ERC_ALU_PASSB;
                `ERC_FOP_COMF:  fop_to_alu = `ERC_ALU_COM;
                `ERC_FOP_INCF:  fop_to_alu = `ERC_ALU_INC;
                `ERC_FOP_RRF:   fop_to_alu = `ERC_ALU_RRC;
                `ERC_FOP_RLF:   fop_to_alu = `ERC_ALU_RLC;
                `ERC_FOP_SWAPF: fop_to_alu = `ERC_ALU_SWAP;
                default:        fop_to_alu = `ERC_ALU_PASSB;
            endcase
        end
    endfunction

    // Flags touched by an ALU operation, bits {zero, nibble, carry}
    function [2:0] alu_flags;
        input [3:0] op;
        begin
            case (op)
                `ERC_ALU_ADD, `ERC_ALU_SUB:   alu_flags = 3'h7;
                `ERC_ALU_RRC, `ERC_ALU_RLC:   alu_flags = 3'h1;
                `ERC_ALU_AND, `ERC_ALU_OR, `ERC_ALU_XOR, `ERC_ALU_INC,
                `ERC_ALU_DEC, `ERC_ALU_COM, `ERC_ALU_CLR: alu_flags = 3'h4;
                default:                      alu_flags = 3'h0;
            endcase
        end
    endfunction

    // Special registers answer inside the core instead of on the data bus
    function is_sfr;
        input [`ERC_DADDR_W-1:0] a;
        begin
            is_sfr = (a == `ERC_ADDR_INDIRECT) || (a == `ERC_ADDR_PCL) ||
                     (a == `ERC_ADDR_STATUS) || (a == `ERC_ADDR_FSR);
        end
    endfunction

    // Master reset pin: three stages, a change counts once stages two and three agree
    always @(posedge sys_clk_i) begin
        if (rst_i) begin
            mr_s1_reg   <= 1'b0;
            mr_s2_reg   <= 1'b0;
            mr_s3_reg   <= 1'b0;
            mr_hold_reg <= 1'b1;
        end else begin
            mr_s1_reg <= master_reset_pin_n_i;
            mr_s2_reg <= mr_s1_reg;
            mr_s3_reg <= mr_s2_reg;
            if (mr_s2_reg == mr_s3_reg) begin
                mr_hold_reg <= ~mr_s3_reg; // [RULE14]
            end
        end
    end

    assign core_rst = rst_i | mr_hold_reg; // [RULE14]

    // Quarter-rate divider; the commit phase is the instruction-cycle enable
    always @* begin
        phase_next = phase_reg + 2'h1;
    end

    assign commit_en = (phase_reg == `ERC_PH_COMMIT);

    always @(posedge sys_clk_i) begin
        if (core_rst) begin
            phase_reg <= 2'h0;
            rate_reg  <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            // High for the second half of each instruction cycle
            rate_reg  <= rc_mode_i & (phase_next >= `ERC_RATE_HIGH_FROM); // [RULE13]
        end
    end

    // Decode of the instruction held in the execute stage
    assign is_goto = instr_reg[11];
    assign is_lit  = (instr_reg[11:10] == 2'b01);
    assign is_file = (instr_reg[11:10] == 2'b00);
    assign fop     = instr_reg[9:6];
    assign lop     = instr_reg[9:8];
    assign dest_f  = instr_reg[5];
    assign faddr   = instr_reg[4:0];
    // Address zero goes through the pointer register
    assign eaddr   = (faddr == `ERC_ADDR_INDIRECT) ? fsr_reg[4:0] : faddr; // [RULE5]

    assign alu_op = is_lit ? ((lop == `ERC_LOP_MOVLW) ? `ERC_ALU_PASSB :
                              (lop == `ERC_LOP_ADDLW) ? `ERC_ALU_ADD :
                              (lop == `ERC_LOP_ANDLW) ? `ERC_ALU_AND : `ERC_ALU_XOR)
                           : fop_to_alu(fop);
    assign flag_mask = (is_lit | is_file) ? alu_flags(alu_op) : 3'h0; // [RULE11]

    // File ops CLR to SWAPF pick their destination by one bit; MOVWF always writes the file
    assign wr_file = is_file && ((fop == `ERC_FOP_MOVWF) ||
                     (dest_f && fop >= `ERC_FOP_CLR && fop <= `ERC_FOP_SWAPF)); // [RULE9]
    assign wr_acc  = is_lit || (is_file && !dest_f &&
                     fop >= `ERC_FOP_CLR && fop <= `ERC_FOP_SWAPF); // [RULE8] [RULE9]
    assign needs_read = is_file && fop >= `ERC_FOP_SUBWF && fop <= `ERC_FOP_SWAPF;

    // Second operand is a file register or the literal in the word
    assign alu_b = is_lit ? instr_reg[7:0] : opnd_reg; // [RULE8]

    erc_alu u_alu (
        .op_i     (alu_op),
        .acc_i    (acc_reg),
        .opnd_i   (alu_b),
        .carry_i  (status_reg[`ERC_ST_C]),
        .result_o (alu_y),
        .carry_o  (alu_c),
        .nibble_o (alu_nib),
        .zero_o   (alu_z)
    ); // [RULE6] [RULE7] [RULE12]

    assign status_written = wr_file && (eaddr == `ERC_ADDR_STATUS);

    // Fetch, operand read, execute and write back
    always @(posedge sys_clk_i) begin
        if (core_rst) begin
            pc_reg     <= RESET_PC[PC_W-1:0];
            instr_reg  <= `ERC_NOP_WORD;
            acc_reg    <= `ERC_W_RESET;
            fsr_reg    <= `ERC_FSR_RESET;
            status_reg <= `ERC_STATUS_RESET;
            opnd_reg   <= 8'h00;
            daddr_reg  <= {`ERC_DADDR_W{1'b0}};
            dwdata_reg <= 8'h00;
            dwe_reg    <= 1'b0;
            dre_reg    <= 1'b0;
        end else begin
            dwe_reg <= 1'b0;
            dre_reg <= 1'b0;
            // Read strobe one phase after the write strobe, so they never meet
            if (phase_reg == `ERC_PH_READ && needs_read && !is_sfr(eaddr)) begin
                dre_reg   <= 1'b1;
                daddr_reg <= eaddr;
            end
            if (phase_reg == `ERC_PH_CAPTURE) begin
                if (!is_sfr(eaddr)) begin
                    opnd_reg <= data_rdata_i;
                end else if (eaddr == `ERC_ADDR_PCL) begin
                    opnd_reg <= pc_reg[7:0]; // [RULE5]
                end else if (eaddr == `ERC_ADDR_STATUS) begin
                    opnd_reg <= {5'h00, status_reg};
                end else if (eaddr == `ERC_ADDR_FSR) begin
                    opnd_reg <= fsr_reg;
                end else begin
                    // Pointer aimed at the indirect address reads as zero
                    opnd_reg <= 8'h00;
                end
            end
            if (commit_en) begin
                // Default fetch: next word enters execute while its successor is addressed
                instr_reg <= prog_data_i; // [RULE1] [RULE2]
                pc_reg    <= pc_reg + {{(PC_W-1){1'b0}}, 1'b1}; // [RULE4]
                if (wr_acc) begin
                    acc_reg <= alu_y; // [RULE10]
                end
                // An explicit write to status overrides the flag update
                if (!status_written) begin
                    if (flag_mask[0]) begin
                        status_reg[`ERC_ST_C] <= alu_c; // [RULE11] [RULE12]
                    end
                    if (flag_mask[1]) begin
                        status_reg[`ERC_ST_NIB] <= alu_nib; // [RULE11] [RULE12]
                    end
                    if (flag_mask[2]) begin
                        status_reg[`ERC_ST_Z] <= alu_z; // [RULE15]
                    end
                end
                if (wr_file) begin
                    if (eaddr == `ERC_ADDR_PCL) begin
                        // Computed jump: drop the prefetched word
                        pc_reg    <= {{(PC_W-8){1'b0}}, alu_y}; // [RULE5] [RULE3]
                        instr_reg <= `ERC_NOP_WORD; // [RULE3]
                    end else if (eaddr == `ERC_ADDR_STATUS) begin
                        status_reg <= alu_y[2:0];
                    end else if (eaddr == `ERC_ADDR_FSR) begin
                        fsr_reg <= alu_y;
                    end else if (!is_sfr(eaddr)) begin
                        dwe_reg    <= 1'b1;
                        daddr_reg  <= eaddr;
                        dwdata_reg <= alu_y;
                    end
                end
                if (is_goto) begin
                    // Target beyond the fitted memory wraps by truncation
                    pc_reg    <= instr_reg[PC_W-1:0]; // [RULE4]
                    instr_reg <= `ERC_NOP_WORD; // [RULE3]
                end
            end
        end
    end

    assign instruction_rate_output_o = rate_reg;
    assign prog_addr_o               = pc_reg; // [RULE1]
    assign data_addr_o               = daddr_reg;
    assign data_wdata_o              = dwdata_reg;
    assign data_we_o                 = dwe_reg;
    assign data_re_o                 = dre_reg;
    assign acc_o                     = acc_reg;
    assign status_o                  = status_reg;

endmodule
